// *** design/fifo_pkg.sv ***
// constants, types and helpers for the dual-domain buffer and its flags
// assumes both domains share one master clock and advance on tick enables
package fifo_pkg;

  // storage geometry: depth is a power of two
  localparam int ADDR_W       = 4;
  localparam int PTR_W        = ADDR_W + 1;
  localparam int CNT_W        = ADDR_W + 1;
  localparam int DATA_W       = 8;
  localparam int buffer_depth = 16;

  // build-time defaults
  localparam int DEF_SYNC_DEPTH  = 3;
  localparam int DEF_USEDW_DELAY = 1;

  // cross-domain latencies in destination edges, at the default sync depth
  localparam int OLDER_FLAG_LAT  = 6;
  localparam int OLDER_CNT_LAT   = 5;
  localparam int SPEED_FLAG_LAT  = 3;
  localparam int SPEED_CNT_LAT   = 4;
  localparam int AREA_FLAG_LAT   = 2;
  localparam int AREA_CNT_LAT    = 3;
  localparam int OLDER_RDFULL_LAT = 4;

  // reset values
  localparam logic [PTR_W-1:0]  PTR_RST = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_RST = 5'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // full thresholds: exact, or one below depth for the conservative estimate
  localparam logic [CNT_W-1:0] FULL_EXACT = 5'h10;
  localparam logic [CNT_W-1:0] FULL_EARLY = 5'h0f;

  // latency variant, chosen once at build time
  typedef enum logic [1:0] {
    VAR_OLDER = 2'b00,
    VAR_SPEED = 2'b01,
    VAR_AREA  = 2'b10
  } variant_type;

  // flag latency for a variant and a chosen sync depth
  function automatic int flag_lat(variant_type v, int depth);
    case (v)
      VAR_OLDER: return depth + OLDER_FLAG_LAT - DEF_SYNC_DEPTH;
      VAR_AREA:  return depth + AREA_FLAG_LAT - DEF_SYNC_DEPTH;
      default:   return depth + SPEED_FLAG_LAT - DEF_SYNC_DEPTH;
    endcase
  endfunction

  // used-word latency for a variant and a chosen sync depth
  function automatic int cnt_lat(variant_type v, int depth);
    case (v)
      VAR_OLDER: return depth + OLDER_CNT_LAT - DEF_SYNC_DEPTH;
      VAR_AREA:  return depth + AREA_CNT_LAT - DEF_SYNC_DEPTH;
      default:   return depth + SPEED_CNT_LAT - DEF_SYNC_DEPTH;
    endcase
  endfunction

  // binary to gray
  function automatic logic [PTR_W-1:0] b2g(logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // gray to binary
  function automatic logic [PTR_W-1:0] g2b(logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// *** design/fifo_flags.sv ***
// dual-domain buffer with guarded requests, gray pointer crossings and
// variant-dependent flag latencies on both sides
// assumes one master clock; each domain advances on its tick enable, but the used-word outputs load on every master edge
//
// Local design decisions: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module fifo_flags #(
  parameter fifo_pkg::variant_type variant   = fifo_pkg::VAR_SPEED,
  parameter bit  overflow_guard              = 1'b1,
  parameter bit  underflow_guard             = 1'b1,
  parameter bit  lookahead_select            = 1'b0,
  parameter int  rd_used_delay               = fifo_pkg::DEF_USEDW_DELAY,
  parameter int  wr_used_delay               = fifo_pkg::DEF_USEDW_DELAY,
  parameter int  to_read_sync_depth          = fifo_pkg::DEF_SYNC_DEPTH,
  parameter int  to_write_sync_depth         = fifo_pkg::DEF_SYNC_DEPTH
) (
  // clock and resets
  input  wire logic                        mclk_in,
  input  wire logic                        rst_in,
  input  wire logic                        clear_in,
  // domain edge enables
  input  wire logic                        wr_tick_in,
  input  wire logic                        rd_tick_in,
  // write side
  input  wire logic                        wr_req_in,
  input  wire logic [fifo_pkg::DATA_W-1:0] wr_data_in,
  output var  logic                        wr_empty_out,
  output var  logic                        wr_full_out,
  output var  logic [fifo_pkg::CNT_W-1:0]  wr_used_out,
  // read side
  input  wire logic                        rd_req_in,
  output var  logic [fifo_pkg::DATA_W-1:0] rd_data_out,
  output var  logic                        rd_empty_out,
  output var  logic                        rd_full_out,
  output var  logic [fifo_pkg::CNT_W-1:0]  rd_used_out
);
  import fifo_pkg::*;

  // derived pipeline shapes, set by the variant choice and the sync depths
  localparam int RD_E   = flag_lat(variant, to_read_sync_depth);
  localparam int RD_C   = cnt_lat(variant, to_read_sync_depth);
  localparam int WR_E   = flag_lat(variant, to_write_sync_depth);
  localparam int WR_C   = cnt_lat(variant, to_write_sync_depth);
  localparam int RD_TE  = RD_E - 2;
  localparam int RD_TC  = RD_C - 3;
  localparam int WR_TE  = WR_E - 2;
  localparam int WR_TC  = WR_C - 3;
  localparam int RS_LEN = ((RD_TE > RD_TC) ? RD_TE : RD_TC) + 1;
  localparam int WS_LEN = ((WR_TE > WR_TC) ? WR_TE : WR_TC) + 1;
  // one history stage per read tick, so the flag register lands on the fifth tick
  localparam int HIST_LEN = OLDER_RDFULL_LAT;
  localparam bit OLDER  = (variant == VAR_OLDER);

  // storage
  logic [DATA_W-1:0] mem [buffer_depth];

  // pointers, both domains
  logic [PTR_W-1:0] wr_bin_r;
  logic [PTR_W-1:0] wr_bin_nxt;
  logic [PTR_W-1:0] wr_gray_r;
  logic [PTR_W-1:0] rd_bin_r;
  logic [PTR_W-1:0] rd_bin_nxt;
  logic [PTR_W-1:0] rd_gray_r;

  // synchroniser pipelines and read pointer history
  logic [PTR_W-1:0] wsync_r [RS_LEN];
  logic [PTR_W-1:0] rsync_r [WS_LEN];
  logic [PTR_W-1:0] rd_hist_r [HIST_LEN];

  // used-word pipelines, index 0 is the raw count
  logic [CNT_W-1:0] rd_cnt_r [rd_used_delay+1];
  logic [CNT_W-1:0] wr_cnt_r [wr_used_delay+1];

  // misc
  logic             clr;
  logic             wr_ok;
  logic             rd_ok;
  logic [PTR_W-1:0] wr_at_e;
  logic [PTR_W-1:0] wr_at_c;
  logic [PTR_W-1:0] rd_at_e;
  logic [PTR_W-1:0] rd_at_c;
  logic [PTR_W-1:0] rd_full_ptr;

  // full test: exact, or one early for the conservative estimate
  function automatic logic is_full(logic [PTR_W-1:0] wp, logic [PTR_W-1:0] rp);
    logic [CNT_W-1:0] diff;
    diff = wp - rp;
    if (OLDER) begin
      return diff >= FULL_EARLY;
    end
    return diff == FULL_EXACT;
  endfunction

  // request qualification
  assign clr   = rst_in || clear_in;
  assign wr_ok = wr_tick_in && wr_req_in && !(overflow_guard && wr_full_out);
  assign rd_ok = rd_tick_in && rd_req_in && !(underflow_guard && rd_empty_out);
  assign wr_bin_nxt = wr_bin_r + {{(PTR_W-1){1'b0}}, wr_ok};
  assign rd_bin_nxt = rd_bin_r + {{(PTR_W-1){1'b0}}, rd_ok};

  // synchronised pointer taps, decoded back to binary
  assign wr_at_e = g2b(wsync_r[RD_TE]);
  assign wr_at_c = g2b(wsync_r[RD_TC]);
  assign rd_at_e = g2b(rsync_r[WR_TE]);
  assign rd_at_c = g2b(rsync_r[WR_TC]);
  assign rd_full_ptr = OLDER ? rd_hist_r[HIST_LEN-1] : rd_bin_nxt;

  // storage write
  always_ff @(posedge mclk_in) begin
    if (wr_ok) begin
      mem[wr_bin_r[ADDR_W-1:0]] <= wr_data_in;
    end
  end

  // write pointer, binary and gray
  always_ff @(posedge mclk_in) begin
    if (clr) begin
      wr_bin_r  <= PTR_RST;
      wr_gray_r <= PTR_RST;
    end else begin
      wr_bin_r  <= wr_bin_nxt;
      wr_gray_r <= b2g(wr_bin_nxt);
    end
  end

  // read pointer, binary and gray
  always_ff @(posedge mclk_in) begin
    if (clr) begin
      rd_bin_r  <= PTR_RST;
      rd_gray_r <= PTR_RST;
    end else begin
      rd_bin_r  <= rd_bin_nxt;
      rd_gray_r <= b2g(rd_bin_nxt);
    end
  end

  // write gray pointer into the read domain
  for (genvar i = 0; i < RS_LEN; i++) begin : g_wsync
    always_ff @(posedge mclk_in) begin
      if (clr) begin
        wsync_r[i] <= PTR_RST;
      end else if (rd_tick_in) begin
        if (i == 0) begin
          wsync_r[i] <= wr_gray_r;
        end else begin
          wsync_r[i] <= wsync_r[(i == 0) ? 0 : i-1];
        end
      end
    end
  end

  // read gray pointer into the write domain
  for (genvar i = 0; i < WS_LEN; i++) begin : g_rsync
    always_ff @(posedge mclk_in) begin
      if (clr) begin
        rsync_r[i] <= PTR_RST;
      end else if (wr_tick_in) begin
        if (i == 0) begin
          rsync_r[i] <= rd_gray_r;
        end else begin
          rsync_r[i] <= rsync_r[(i == 0) ? 0 : i-1];
        end
      end
    end
  end

  // delayed read pointer for the slow read-side full flag
  for (genvar i = 0; i < HIST_LEN; i++) begin : g_hist
    always_ff @(posedge mclk_in) begin
      if (clr) begin
        rd_hist_r[i] <= PTR_RST;
      end else if (rd_tick_in) begin
        rd_hist_r[i] <= (i == 0) ? rd_bin_nxt : rd_hist_r[(i == 0) ? 0 : i-1];
      end
    end
  end

  // read-side empty and full flags
  always_ff @(posedge mclk_in) begin
    if (clr) begin
      rd_empty_out <= 1'b1;
      rd_full_out  <= 1'b0;
    end else if (rd_tick_in) begin
      rd_empty_out <= (rd_bin_nxt == wr_at_e);
      rd_full_out  <= is_full(wr_at_e, rd_full_ptr);
    end
  end

  // write-side empty and full flags
  always_ff @(posedge mclk_in) begin
    if (clr) begin
      wr_empty_out <= 1'b1;
      wr_full_out  <= 1'b0;
    end else if (wr_tick_in) begin
      wr_empty_out <= (wr_bin_nxt == rd_at_e);
      wr_full_out  <= is_full(wr_bin_nxt, rd_at_e);
    end
  end

  // read-side used words plus delay stages
  for (genvar i = 0; i <= rd_used_delay; i++) begin : g_rcnt
    always_ff @(posedge mclk_in) begin
      if (clr) begin
        rd_cnt_r[i] <= CNT_RST;
      end else if (rd_tick_in) begin
        if (i == 0) begin
          rd_cnt_r[i] <= wr_at_c - rd_bin_nxt;
        end else begin
          rd_cnt_r[i] <= rd_cnt_r[(i == 0) ? 0 : i-1];
        end
      end
    end
  end

  // write-side used words plus delay stages
  for (genvar i = 0; i <= wr_used_delay; i++) begin : g_wcnt
    always_ff @(posedge mclk_in) begin
      if (clr) begin
        wr_cnt_r[i] <= CNT_RST;
      end else if (wr_tick_in) begin
        if (i == 0) begin
          wr_cnt_r[i] <= wr_bin_nxt - rd_at_c;
        end else begin
          wr_cnt_r[i] <= wr_cnt_r[(i == 0) ? 0 : i-1];
        end
      end
    end
  end

  // count outputs, last stage of each pipe
  always_ff @(posedge mclk_in) begin
    if (clr) begin
      rd_used_out <= CNT_RST;
      wr_used_out <= CNT_RST;
    end else begin
      rd_used_out <= rd_cnt_r[rd_used_delay];
      wr_used_out <= wr_cnt_r[wr_used_delay];
    end
  end

  // read data: legacy on request, lookahead shows the head word
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_data_out <= DATA_RST;
    end else if (lookahead_select && rd_tick_in) begin
      rd_data_out <= mem[rd_bin_nxt[ADDR_W-1:0]];
    end else if (!lookahead_select && rd_ok) begin
      rd_data_out <= mem[rd_bin_r[ADDR_W-1:0]];
    end
  end

  // checks

  // true occupancy, for checks only
  logic [CNT_W-1:0] occ;
  assign occ = wr_bin_r - rd_bin_r;

  chk_ovf_write_blocked: assert property (@(posedge mclk_in) disable iff (clr)
    (overflow_guard && wr_tick_in && wr_req_in && wr_full_out) |=> $stable(wr_bin_r))
    else $error("write taken while full");

  chk_udf_read_blocked: assert property (@(posedge mclk_in) disable iff (clr)
    (underflow_guard && rd_tick_in && rd_req_in && rd_empty_out) |=> $stable(rd_bin_r))
    else $error("read taken while empty");

  chk_wr_empty_now: assert property (@(posedge mclk_in) disable iff (clr)
    wr_ok |=> !wr_empty_out)
    else $error("write side empty after write");

  chk_gray_one_bit: assert property (@(posedge mclk_in) disable iff (clr)
    (!$past(rst_in) && !$past(clear_in)) |-> ($countones(wr_gray_r ^ $past(wr_gray_r)) <= 1))
    else $error("write gray pointer moved by more than one bit");

  chk_no_overrun_occ: assert property (@(posedge mclk_in) disable iff (clr)
    overflow_guard |-> (occ <= FULL_EXACT))
    else $error("occupancy above depth");

  chk_empty_is_safe: assert property (@(posedge mclk_in) disable iff (clr)
    (!rd_empty_out) |-> (occ != CNT_RST))
    else $error("not empty while nothing stored");

  chk_fifo_clear: assert property (@(posedge mclk_in)
    clear_in |=> (rd_empty_out && wr_empty_out && !wr_full_out && wr_used_out == CNT_RST))
    else $error("clear did not empty flags");

  chk_rd_full_drop: assert property (@(posedge mclk_in) disable iff (clr)
    (!OLDER && rd_ok) |=> !rd_full_out)
    else $error("read side full after read");

  // full may rise early, but never below one under depth against the crossed read pointer
  chk_wr_full_early: assert property (@(posedge mclk_in) disable iff (clr)
    $rose(wr_full_out) |-> (CNT_W'(wr_bin_r - $past(rd_at_e)) >= FULL_EARLY))
    else $error("write full raised below one under depth");

endmodule

`default_nettype wire

// *** verif/far_side.sv ***
// producer and consumer request logic that faces the buffer ports
// assumes the bench drives ticks, data and the control levels
`timescale 1ns/1ps
`default_nettype none
module far_side (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // control from the bench
  input  wire logic push_en_in,
  input  wire logic pop_en_in,
  input  wire logic force_in,
  input  wire logic stall_in,
  // buffer flags
  input  wire logic wr_full_in,
  input  wire logic rd_empty_in,
  // requests
  output var  logic wr_req_out,
  output var  logic rd_req_out
);
  // ask only while the flag allows, unless told to push past it
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_req_out <= 1'b0;
      rd_req_out <= 1'b0;
    end else begin
      wr_req_out <= push_en_in & ~stall_in & (force_in | ~wr_full_in);
      rd_req_out <= pop_en_in & ~stall_in & (force_in | ~rd_empty_in);
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench: queue model against the buffer, speed variant
// assumes the default build parameters of the buffer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fifo_pkg::*;
  logic              mclk_in, rst_in, clear_in, wr_tick, rd_tick, wr_req, rd_req;
  logic              push_en, pop_en, force_on, stall, rd_chk;
  logic              wr_empty, wr_full, rd_empty, rd_full;
  logic [DATA_W-1:0] wr_data, rd_data, exp_d;
  logic [CNT_W-1:0]  wr_used, rd_used;
  logic [15:0]       lf;
  logic [DATA_W-1:0] q[$];
  int                errors, num_checks, ph, meas, lat;

  fifo_flags dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .clear_in(clear_in),
    .wr_tick_in(wr_tick), .rd_tick_in(rd_tick), .wr_req_in(wr_req),
    .wr_data_in(wr_data), .wr_empty_out(wr_empty), .wr_full_out(wr_full),
    .wr_used_out(wr_used), .rd_req_in(rd_req), .rd_data_out(rd_data),
    .rd_empty_out(rd_empty), .rd_full_out(rd_full), .rd_used_out(rd_used));
  far_side far_u (.mclk_in(mclk_in), .rst_in(rst_in), .push_en_in(push_en),
    .pop_en_in(pop_en), .force_in(force_on), .stall_in(stall),
    .wr_full_in(wr_full), .rd_empty_in(rd_empty),
    .wr_req_out(wr_req), .rd_req_out(rd_req));

  // pseudo-random sequence step
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_q(int n);
    for (int i = 0; i < 400 && q.size() != n; i++) @(posedge mclk_in);
    // a level never reached counts as a mismatch
    chk("queue_level", 8'(q.size()), 8'(n));
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // random ticks, stalls and data, so both domains run at uneven rates
  always @(posedge mclk_in) begin
    lf <= lfsr(lf);
    wr_tick <= |lf[1:0];
    rd_tick <= |lf[3:2];
    stall <= &lf[6:4];
    wr_data <= lf[15:8];
  end

  // model: sees pre-edge values, checks last edge's results, then updates
  always @(posedge mclk_in) begin
    if (rd_chk) chk("rd_data", rd_data, exp_d);
    rd_chk = 1'b0;
    if (ph == 1) begin
      chk("wr_empty", wr_empty, q.size() == 0);
      chk("wr_full", wr_full, q.size() == buffer_depth);
    end
    if (ph == 2) begin
      chk("rd_empty", rd_empty, q.size() == 0);
      chk("rd_full", rd_full, q.size() == buffer_depth);
    end
    if (meas == 1) begin
      if (rd_empty === 1'b0) begin
        chk("rd_empty_lat", 8'(lat), 8'(SPEED_FLAG_LAT));
        meas = 0;
      end else if (rd_tick) lat++;
    end
    if (meas == 2) begin
      if (wr_full === 1'b0) begin
        chk("wr_full_lat", 8'(lat), 8'(SPEED_FLAG_LAT));
        meas = 0;
      end else if (wr_tick) lat++;
    end
    // guarded acceptance, in order
    if (wr_tick && wr_req && q.size() < buffer_depth) begin
      if (q.size() == 0 && ph == 1) begin
        meas = 1;
        lat = 0;
      end
      q.push_back(wr_data);
    end
    if (rd_tick && rd_req && q.size() > 0) begin
      if (q.size() == buffer_depth) begin
        meas = 2;
        lat = 0;
      end
      exp_d = q.pop_front();
      rd_chk = 1'b1;
    end
    if (clear_in) q.delete();
  end

  // watchdog: the whole run needs under two thousand cycles
  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    errors = 0;
    num_checks = 0;
    ph = 0;
    meas = 0;
    lat = 0;
    rd_chk = 1'b0;
    lf = 16'h071a;
    rst_in = 1'b1;
    clear_in = 1'b0;
    wr_tick = 1'b0;
    rd_tick = 1'b0;
    push_en = 1'b0;
    pop_en = 1'b0;
    force_on = 1'b0;
    stall = 1'b0;
    wr_data = 8'h00;
    exp_d = 8'h00;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    chk("rst_flags", {wr_empty, wr_full, rd_empty, rd_full}, 8'h0a);
    chk("rst_data", rd_data, 8'h00);
    // reads on an empty buffer are refused
    ph <= 2;
    pop_en <= 1'b1;
    force_on <= 1'b1;
    repeat (40) @(posedge mclk_in);
    pop_en <= 1'b0;
    ph <= 0;
    repeat (40) @(posedge mclk_in);
    chk("rd_used_0", rd_used, 8'h00);
    // fill, then keep pushing into the full buffer
    ph <= 1;
    push_en <= 1'b1;
    wait_q(buffer_depth);
    repeat (30) @(posedge mclk_in);
    push_en <= 1'b0;
    repeat (40) @(posedge mclk_in);
    chk("wr_used_f", wr_used, 8'(buffer_depth));
    chk("rd_used_f", rd_used, 8'(buffer_depth));
    // drain, then keep popping the empty buffer
    ph <= 2;
    pop_en <= 1'b1;
    wait_q(0);
    repeat (30) @(posedge mclk_in);
    pop_en <= 1'b0;
    repeat (40) @(posedge mclk_in);
    chk("wr_side_e", {wr_empty, wr_full}, 8'h02);
    chk("used_e", wr_used | rd_used, 8'h00);
    // partial fill, then clear
    ph <= 1;
    force_on <= 1'b0;
    push_en <= 1'b1;
    wait_q(5);
    push_en <= 1'b0;
    repeat (40) @(posedge mclk_in);
    ph <= 0;
    clear_in <= 1'b1;
    @(posedge mclk_in);
    clear_in <= 1'b0;
    repeat (40) @(posedge mclk_in);
    chk("clr_flags", {wr_empty, wr_full, rd_empty, rd_full}, 8'h0a);
    chk("clr_used", wr_used | rd_used, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
